//--- design/timer16_params.svh
// constants for the sixteen-bit timer/counter: offsets, fields, resets
// How it works
// R1: count rises from 0000h to ffffh, wraps to zero, sets overflow flag.
// R2: overflow flag at flag bit 0; enable bit 0 gates the interrupt.
// R3: run bit (control bit 0) lets counting advance; clear holds count.
// R4: source bit clear counts instruction cycles; set counts external rising edges.
// R5: prescale field at control bits 5:4; code 11 divides by eight.
// R6: prescale codes 10, 01, 00 divide by four, two and one.
// R7: with external source, sync bit 1 bypasses synchroniser, 0 synchronises.
// R8: crystal oscillator runs only while oscillator enable bit 3 is set.
// R9: oscillator enable forces both oscillator pins to inputs reading zero.
// R10: read-only control bit 6 shows system clock comes from this oscillator.
// R11: compare-mode trigger with mode 1011 resets the count, starts conversion.
// R12: a compare-trigger reset never sets the overflow flag; here a trigger in the cycle of an increment from ffffh still sets it.
// R13: software uses timer or synchronised mode for trigger reset.
// R14: a counter write in the trigger cycle wins over the reset.
// R15: wide mode maps high address to buffer; low read loads buffer.
// R16: wide mode high writes go to buffer; low write loads both bytes.
// R17: wide mode low writes clear prescaler; buffer writes do not.
// R18: wide mode off exposes high and low bytes directly, each separately.
// R19: unsynchronised external counting continues while system clock is stopped; here it still needs sys_clk running.
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define ADDR_CONTROL     4'h0
`define ADDR_COUNT_LOW   4'h1
`define ADDR_COUNT_HIGH  4'h2
`define ADDR_FLAGS       4'h3
`define ADDR_ENABLES     4'h4
`define BIT_RUN          0
`define BIT_CLK_SRC      1
`define BIT_SYNC_BYPASS  2
`define BIT_OSC_ENABLE   3
`define BIT_PS_LO        4
`define BIT_PS_HI        5
`define BIT_SYSCLK_STAT  6
`define BIT_WIDE_ACCESS  7
`define BIT_OVERFLOW     0
`define CONTROL_RESET    8'h00
`define COUNT_RESET      16'h0000
`define COMPARE_TRIG_MODE 4'hb
`define INSTR_DIV        2'h3
`endif

//--- design/timer16_pkg.sv
// types for the sixteen-bit timer/counter
package timer16_pkg;
    typedef enum logic [1:0]
    {
        PS_DIV1 = 2'b00,
        PS_DIV2 = 2'b01,
        PS_DIV4 = 2'b10,
        PS_DIV8 = 2'b11
    } prescale_type;
endpackage

//--- design/timer16.sv
// sixteen-bit timer/counter with register port, prescaler and overflow interrupt
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "timer16_params.svh"
module timer16
    import timer16_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       ext_clk_i,
    input  wire logic       osc_in_pin_i,
    input  wire logic [1:0] pin_direction_bits_i,
    input  wire logic [1:0] pin_out_data_i,
    output logic      [1:0] pin_oe_o,
    output logic      [1:0] pin_read_o,
    output logic            osc_run_o,
    input  wire logic       sysclk_from_osc_i,
    input  wire logic [3:0] compare_mode_field_i,
    input  wire logic       compare_match_i,
    input  wire logic       adc_enable_i,
    output logic            adc_start_o,
    output logic            irq_o
);
    logic [7:0]  control_reg;
    logic [15:0] count_reg;
    logic [7:0]  high_buf_reg;
    logic [2:0]  ps_cnt_reg;
    logic [1:0]  instr_cnt_reg;
    logic        sync1_reg;
    logic        sync2_reg;
    logic        ext_prev_reg;
    logic        flags_reg;
    logic        enables_reg;
    logic [7:0]  rdata_reg;
    logic        adc_start_reg;

    function automatic logic [2:0] ps_limit(input prescale_type sel);
        case (sel)
            PS_DIV1: ps_limit = 3'h0;
            PS_DIV2: ps_limit = 3'h1;
            PS_DIV4: ps_limit = 3'h3;
            default: ps_limit = 3'h7;
        endcase
    endfunction

    wire run         = control_reg[`BIT_RUN];
    wire ext_sel     = control_reg[`BIT_CLK_SRC];
    wire bypass      = control_reg[`BIT_SYNC_BYPASS];
    wire osc_en      = control_reg[`BIT_OSC_ENABLE];
    wire wide        = control_reg[`BIT_WIDE_ACCESS];
    wire [1:0] ps_raw = control_reg[`BIT_PS_HI:`BIT_PS_LO];
    wire prescale_type ps_sel = prescale_type'(ps_raw);

    wire wr_ctl   = wr_i && (addr_i == `ADDR_CONTROL);
    wire wr_low   = wr_i && (addr_i == `ADDR_COUNT_LOW);
    wire wr_high  = wr_i && (addr_i == `ADDR_COUNT_HIGH);
    wire wr_flags = wr_i && (addr_i == `ADDR_FLAGS);
    wire wr_en    = wr_i && (addr_i == `ADDR_ENABLES);
    wire rd_low   = rd_i && (addr_i == `ADDR_COUNT_LOW);

    // external source: crystal when enabled, else the clock pin [R4] [R8]
    wire ext_src  = osc_en ? osc_in_pin_i : ext_clk_i;
    // bypass path samples once, synchronised path uses the second stage [R7]
    // single clock: unsynchronised counting still needs sys_clk running [R19]
    wire ext_lvl  = bypass ? sync1_reg : sync2_reg;
    wire ext_rise = ext_lvl && !ext_prev_reg;
    wire tick_int = (instr_cnt_reg == `INSTR_DIV);
    wire src_tick = ext_sel ? ext_rise : tick_int;            // [R4]
    wire ps_done  = (ps_cnt_reg == ps_limit(ps_sel));          // [R5] [R6]
    wire inc      = run && src_tick && ps_done;                // [R3]
    wire wrap     = inc && (count_reg == 16'hffff);            // [R1]
    wire trig     = compare_match_i && (compare_mode_field_i == `COMPARE_TRIG_MODE);
    wire any_cnt_wr = wr_low || (wr_high && !wide);

    wire [15:0] count_next =
        wr_low  ? (wide ? {high_buf_reg, wdata_i}            // [R16]
                        : {count_reg[15:8], wdata_i})        // [R18]
      : (wr_high && !wide) ? {wdata_i, count_reg[7:0]}       // [R18]
      : trig    ? `COUNT_RESET                               // [R11] [R14]
      : inc     ? count_reg + 16'h0001                       // [R1]
      : count_reg;

    wire [7:0] control_next = wr_ctl ? {wdata_i[7], 1'b0, wdata_i[5:0]} : control_reg;
    wire [7:0] high_read = wide ? high_buf_reg : count_reg[15:8];   // [R15]
    wire [7:0] rdata_next =
        !rd_i ? 8'h00
      : (addr_i == `ADDR_CONTROL)    ? {control_reg[7], sysclk_from_osc_i,
                                        control_reg[5:0]}          // [R10]
      : (addr_i == `ADDR_COUNT_LOW)  ? count_reg[7:0]
      : (addr_i == `ADDR_COUNT_HIGH) ? high_read
      : (addr_i == `ADDR_FLAGS)      ? {7'h00, flags_reg}
      : (addr_i == `ADDR_ENABLES)    ? {7'h00, enables_reg}
      : 8'h00;

    // set wins over write-one-to-clear; a trigger reset sets it only if an increment from ffffh falls in that cycle [R2] [R12]
    wire flags_next = wrap || (flags_reg && !(wr_flags && wdata_i[`BIT_OVERFLOW]));

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            control_reg   <= `CONTROL_RESET;
            count_reg     <= `COUNT_RESET;
            high_buf_reg  <= 8'h00;
            ps_cnt_reg    <= 3'h0;
            instr_cnt_reg <= 2'h0;
            sync1_reg     <= 1'b0;
            sync2_reg     <= 1'b0;
            ext_prev_reg  <= 1'b0;
            flags_reg     <= 1'b0;
            enables_reg   <= 1'b0;
            rdata_reg     <= 8'h00;
            adc_start_reg <= 1'b0;
        end
        else
        begin
            control_reg   <= control_next;
            count_reg     <= count_next;
            instr_cnt_reg <= instr_cnt_reg + 2'h1;
            sync1_reg     <= ext_src;
            sync2_reg     <= sync1_reg;
            ext_prev_reg  <= ext_lvl;
            flags_reg     <= flags_next;                                  // [R2]
            rdata_reg     <= rdata_next;
            adc_start_reg <= trig && adc_enable_i && !any_cnt_wr;         // [R11]
            if (wr_en)
                enables_reg <= wdata_i[`BIT_OVERFLOW];
            if (wide && wr_high)
                high_buf_reg <= wdata_i;                                  // [R16]
            else if (wide && rd_low)
                high_buf_reg <= count_reg[15:8];                          // [R15]
            if (wr_low && wide)
                ps_cnt_reg <= 3'h0;                                       // [R17]
            else if (run && src_tick)
                ps_cnt_reg <= ps_done ? 3'h0 : ps_cnt_reg + 3'h1;         // [R5]
        end
    end

    assign rdata_o     = rdata_reg;
    assign irq_o       = flags_reg && enables_reg;                        // [R1] [R2]
    assign osc_run_o   = osc_en;                                          // [R8]
    // oscillator enable overrides direction bits and masks reads [R9]
    assign pin_oe_o    = osc_en ? 2'b00 : ~pin_direction_bits_i;
    assign pin_read_o  = osc_en ? 2'b00 : pin_out_data_i;
    assign adc_start_o = adc_start_reg;
endmodule

//--- test/timer16_properties.sv
// port assertions for the timer/counter
`timescale 1ns/1ps
`include "timer16_params.svh"
module timer16_properties (
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] pin_oe_o,
    input wire logic [1:0] pin_read_o,
    input wire logic       osc_run_o,
    input wire logic       sysclk_from_osc_i,
    input wire logic [3:0] compare_mode_field_i,
    input wire logic       compare_match_i,
    input wire logic       adc_enable_i,
    input wire logic       adc_start_o,
    input wire logic       irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire trig = compare_match_i && compare_mode_field_i == `COMPARE_TRIG_MODE;
    a_oe_forced: assert property (osc_run_o |-> pin_oe_o == 2'h0) else $error("oe on");
    a_read_zero: assert property (osc_run_o |-> pin_read_o == 2'h0) else $error("pin rd");
    a_osc_follows: assert property (wr_i && addr_i == `ADDR_CONTROL |=>
        osc_run_o == $past(wdata_i[3])) else $error("osc run");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata");
    a_adc_start: assert property (trig && adc_enable_i && !wr_i |=> adc_start_o) else $error("adc");
    a_adc_cause: assert property (adc_start_o |-> $past(trig)) else $error("adc cause");
    a_status_read: assert property (rd_i && addr_i == `ADDR_CONTROL |=>
        rdata_o[6] == $past(sysclk_from_osc_i)) else $error("status");
    a_irq_mask: assert property (wr_i && addr_i == `ADDR_ENABLES && !wdata_i[0] |=>
        !irq_o) else $error("irq mask");
    c_adc: cover property (adc_start_o);
    c_irq: cover property (irq_o);
    c_osc: cover property (osc_run_o);
endmodule
bind timer16 timer16_properties timer16_properties_inst (.sys_clk_i, .rstn_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .pin_oe_o, .pin_read_o, .osc_run_o, .sysclk_from_osc_i,
    .compare_mode_field_i, .compare_match_i, .adc_enable_i, .adc_start_o, .irq_o);

//--- test/compare_source.sv
// compare unit model driving the timer reset trigger
`timescale 1ns/1ps
module compare_source (
    input  wire logic       clk_i,
    output logic      [3:0] mode_o,
    output logic            match_o
);
    initial mode_o = 4'h0;
    initial match_o = 1'b0;
    task automatic fire(input logic [3:0] m); // one-cycle match
        @(posedge clk_i);
        mode_o <= m;
        match_o <= 1'b1;
        @(posedge clk_i);
        match_o <= 1'b0;
    endtask
endmodule

//--- test/test_sixteen_bit_timer_counter.sv
// self-checking bench for the timer/counter
`timescale 1ns/1ps
`include "timer16_params.svh"
module test_sixteen_bit_timer_counter;
    logic       sys_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, ext_clk_i = 0;
    logic       sysclk_from_osc_i = 0, adc_enable_i = 1, osc_run, adc_start, irq_o, cmatch;
    logic [3:0] addr_i = 0, cmode;
    logic [7:0] wdata_i = 0, rdata_o, q, v;
    logic [1:0] dir = 2'h1, oe, prd;
    int         num_errors = 0, n_compared = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    timer16 timer16_inst (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ext_clk_i, .osc_in_pin_i(1'b0), .pin_direction_bits_i(dir), .pin_out_data_i(2'h3),
        .pin_oe_o(oe), .pin_read_o(prd), .osc_run_o(osc_run), .sysclk_from_osc_i,
        .compare_mode_field_i(cmode), .compare_match_i(cmatch), .adc_enable_i,
        .adc_start_o(adc_start), .irq_o);
    compare_source compare_source_inst (.clk_i(sys_clk_i), .mode_o(cmode), .match_o(cmatch));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1;
        @(posedge sys_clk_i);
        wr_i <= 0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1;
        @(posedge sys_clk_i);
        rd_i <= 0;
        #1 q = rdata_o;
    endtask
    task automatic t_regs;
        rd(4'hf); chk("unmapped", 0, q);
        sysclk_from_osc_i <= 1; rd(`ADDR_CONTROL); chk("status", 8'h40, q);
        sysclk_from_osc_i <= 0; wr(`ADDR_CONTROL, 8'h40); rd(`ADDR_CONTROL); chk("ro", 0, q);
    endtask
    task automatic t_ext;
        for (int p = 0; p < 4; p++)
        begin
            wr(`ADDR_CONTROL, 8'h82); wr(`ADDR_COUNT_HIGH, 0); wr(`ADDR_COUNT_LOW, 0);
            wr(`ADDR_CONTROL, 8'(8'h83 | (p << 4) | (p == 3 ? 4 : 0)));
            repeat (16)
            begin
                ext_clk_i <= 1; repeat (4) @(posedge sys_clk_i);
                ext_clk_i <= 0; repeat (4) @(posedge sys_clk_i);
            end
            wr(`ADDR_CONTROL, 8'h80); rd(`ADDR_COUNT_LOW); chk("ext", 16'(16 >> p), q);
        end
    endtask
    task automatic t_int;
        wr(`ADDR_CONTROL, 8'h00); wr(`ADDR_COUNT_LOW, 0); wr(`ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge sys_clk_i);
        wr(`ADDR_CONTROL, 8'h00); rd(`ADDR_COUNT_LOW); v = q; chk("tick", 1, q > 8 && q < 13);
        repeat (20) @(posedge sys_clk_i);
        rd(`ADDR_COUNT_LOW); chk("hold", v, q);
    endtask
    task automatic t_wrap;
        wr(`ADDR_ENABLES, 1); wr(`ADDR_COUNT_HIGH, 8'hff); wr(`ADDR_COUNT_LOW, 8'hfe);
        wr(`ADDR_CONTROL, 8'h01); repeat (20) @(posedge sys_clk_i); wr(`ADDR_CONTROL, 0);
        rd(`ADDR_FLAGS); chk("flag", 1, q); chk("irq", 1, irq_o);
        rd(`ADDR_COUNT_HIGH); chk("wrap", 0, q);
        wr(`ADDR_ENABLES, 0); #1 chk("mask", 0, irq_o);
        wr(`ADDR_FLAGS, 1); rd(`ADDR_FLAGS); chk("clear", 0, q);
    endtask
    task automatic t_trig;
        wr(`ADDR_COUNT_HIGH, 8'h12); compare_source_inst.fire(4'h0);
        #1 chk("no adc", 0, adc_start);
        rd(`ADDR_COUNT_HIGH); chk("no trig", 8'h12, q);
        compare_source_inst.fire(`COMPARE_TRIG_MODE);
        #1 chk("adc", 1, adc_start);
        rd(`ADDR_COUNT_HIGH); chk("trig", 0, q); rd(`ADDR_FLAGS); chk("trig flag", 0, q);
        fork
            compare_source_inst.fire(`COMPARE_TRIG_MODE);
            wr(`ADDR_COUNT_LOW, 8'h77);
        join
        rd(`ADDR_COUNT_LOW); chk("write wins", 8'h77, q);
    endtask
    task automatic t_wide;
        wr(`ADDR_CONTROL, 8'h80); wr(`ADDR_COUNT_HIGH, 8'h5a); rd(`ADDR_COUNT_LOW);
        rd(`ADDR_COUNT_HIGH); chk("buffer", 0, q);
        wr(`ADDR_COUNT_HIGH, 8'h5a); wr(`ADDR_COUNT_LOW, 1); wr(`ADDR_CONTROL, 0);
        rd(`ADDR_COUNT_HIGH); chk("wide hi", 8'h5a, q); rd(`ADDR_COUNT_LOW); chk("lo", 1, q);
        wr(`ADDR_CONTROL, 8'h08); #1 chk("pins", 0, {oe, prd}); chk("osc", 1, osc_run);
        wr(`ADDR_CONTROL, 0); #1 chk("pins off", 8'h23, {oe, 2'h0, prd});
    endtask
    task automatic finish_test;
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1;
        t_regs; t_ext; t_int; t_wrap; t_trig; t_wide;
        finish_test;
    end
    initial
    begin
        repeat (8000) @(posedge sys_clk_i);
        num_errors++;
        finish_test;
    end
endmodule
